// ==== tip_pkg.sv ====
// Constants shared by the timed I/O port and its clock blocks.
// Assumes one tile clock that also stands for the tile reference clock.
package tip_pkg;
   localparam int TIP_PW  = 8;
   localparam int TIP_XW  = 32;
   localparam int TIP_NSH = TIP_XW / TIP_PW;
   localparam int TIP_NCB = 6;
   localparam int TIP_CW  = 16;
   localparam int TIP_DW  = 8;
   localparam int TIP_REF_MHZ = 100;
   localparam int TIP_LINK_LO = 4;
   localparam int TIP_LINK_N  = 4;
   localparam int TIP_NARROW_PIN = 0;
   // Register byte offsets.
   localparam logic [7:0] TIP_OFS_CTRL   = 8'h00;
   localparam logic [7:0] TIP_OFS_DATA   = 8'h04;
   localparam logic [7:0] TIP_OFS_COND   = 8'h08;
   localparam logic [7:0] TIP_OFS_TIME   = 8'h0c;
   localparam logic [7:0] TIP_OFS_COUNT  = 8'h10;
   localparam logic [7:0] TIP_OFS_TSTAMP = 8'h14;
   localparam logic [7:0] TIP_OFS_STATUS = 8'h18;
   localparam logic [7:0] TIP_OFS_MASK   = 8'h1c;
   localparam logic [7:0] TIP_OFS_FLAGS  = 8'h20;
   localparam logic [7:0] TIP_OFS_NARROW = 8'h24;
   localparam logic [7:0] TIP_OFS_CB0    = 8'h40;
   // Control register fields.
   localparam int TIP_C_EN     = 0;
   localparam int TIP_C_OUT    = 1;
   localparam int TIP_C_OC     = 2;
   localparam int TIP_C_COND   = 3;
   localparam int TIP_C_TIMED  = 4;
   localparam int TIP_C_STBIN  = 5;
   localparam int TIP_C_STBOUT = 6;
   localparam int TIP_C_NARROW = 7;
   localparam int TIP_C_LINK   = 8;
   localparam int TIP_C_CB_LSB = 9;
   localparam int TIP_C_CB_W   = 3;
   localparam int TIP_C_W      = 12;
   localparam int TIP_C_NOUT   = 12;
   localparam logic [TIP_C_W:0] TIP_CTRL_RST = 13'h0000;
   // Clock block configuration fields.
   localparam int TIP_CB_EXT = 0;
   localparam int TIP_CB_DIV_LSB = 1;
   localparam int TIP_CB_W = 9;
   localparam logic [8:0] TIP_CB_RST = 9'h000;
   // Sticky status bits.
   localparam int TIP_S_IN   = 0;
   localparam int TIP_S_OUT  = 1;
   localparam int TIP_S_COND = 2;
   localparam int TIP_S_TIME = 3;
   localparam int TIP_S_W    = 4;
   typedef enum logic [1:0] {TIP_IDLE, TIP_RUN} tip_state_t;
endpackage

// ==== tip_clkblk.sv ====
// One clock block: makes a one-cycle tick that paces the ports tied to it.
// Assumes ext_clk_i is already synchronised to clk_i.
`timescale 1ns/10ps
module tip_clkblk
   import tip_pkg::*;
#(
   parameter bit FIXED_REF = 1'b0
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ext_sel_i,
   input  wire logic [TIP_DW-1:0] div_i,
   input  wire logic              ext_clk_i,
   output logic                   tick_o
);
   logic              prev;
   logic [TIP_DW-1:0] dcnt;
   logic              src;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev <= 1'b0;
      end else begin
         prev <= ext_clk_i;
      end
   end

   // The reference source gives an edge every tile cycle; the pin source
   // gives one per rising edge of the external clock.
   assign src = (FIXED_REF || !ext_sel_i) ? 1'b1 : (ext_clk_i & ~prev); // RL13

   // Between source edges the divider holds its count, so that a slow pin
   // clock is still divided and not restarted on every tile cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dcnt   <= '0;
         tick_o <= 1'b0;
      end else if (!src) begin
         tick_o <= 1'b0;
      end else if (!FIXED_REF && dcnt < div_i) begin
         dcnt   <= dcnt + 8'h01; // RL13
         tick_o <= 1'b0;
      end else begin
         dcnt   <= '0;
         tick_o <= 1'b1;
      end
   end
endmodule

// ==== tip_port.sv ====
// Timed I/O port with serializer, port counter, timestamp and six clock blocks.
// Assumes pins, strobe and external clock are asynchronous to clk_i.
// Functional notes
// RL1: Port pins share one direction; fixed widths 1 and 8 are built here.
// RL2: Port drives pins or samples them, optionally waiting for a pin match.
// RL3: Every register access completes in one cycle, never stalls.
// RL4: Open-collector mode pulls low for zero, floats for one, per port.
// RL5: Data passes through a serializer plus a transfer register.
// RL6: A sixteen-bit counter schedules when data moves to or from pins.
// RL7: Counter readable anytime; a programmed count postpones the transfer.
// RL8: Each transfer captures the counter as a readable timestamp.
// RL9: An enabled serial link takes its shared pins from the port.
// RL10: Enabled narrow port owns the shared pin; other wide pins stay usable.
// RL11: The port always transfers its full nominal width.
// RL12: Six clock blocks; block zero is the fixed tile reference clock.
// RL13: A clock block may take a one-bit pin as source, divided.
// RL14: Incoming strobe qualifies input; outgoing strobe marks output data.
// RL15: After reset the port uses clock block zero.
// RL16: Pin conditions go out as scheduler events, not interrupts; here the COND status bit can also raise irq_o through the mask.
// RL17: Pull-downs are enabled while reset is held.
// RL18: Port counter steps once per port clock edge, wraps at 65536.
// RL19: A timed transfer occurs on the first edge where the count matches.
`timescale 1ns/10ps
module tip_port
   import tip_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic [7:0]            addr_i,
   input  wire logic [31:0]           wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic      [31:0]           rdata_o,
   input  wire logic [TIP_PW-1:0]     pins_i,
   output logic      [TIP_PW-1:0]     pins_o,
   output logic      [TIP_PW-1:0]     pins_oe_n_o,
   output logic                       pulldown_o,
   input  wire logic                  ext_clk_i,
   input  wire logic                  strobe_in_i,
   output logic                       strobe_out_o,
   input  wire logic [TIP_LINK_N-1:0] link_tx_i,
   input  wire logic [TIP_LINK_N-1:0] link_oe_n_i,
   output logic      [TIP_LINK_N-1:0] link_rx_o,
   output logic                       irq_o,
   output logic                       event_o
);
   logic [TIP_C_W:0]    ctrl;
   logic [TIP_PW-1:0]   cond;
   logic [TIP_CW-1:0]   ttime;
   logic [TIP_CW-1:0]   cnt;
   logic [TIP_CW-1:0]   tstamp;
   logic [TIP_S_W-1:0]  status;
   logic [TIP_S_W-1:0]  mask;
   logic [TIP_S_W-1:0]  ev;
   logic [TIP_CB_W-1:0] cbcfg [TIP_NCB];
   logic [TIP_NCB-1:0]  cb_tick;
   logic [TIP_PW-1:0]   pin_m;
   logic [TIP_PW-1:0]   pin_s;
   logic                stb_m;
   logic                stb_s;
   logic                eck_m;
   logic                eck_s;
   logic [TIP_XW-1:0]   xout;
   logic                out_full;
   logic [TIP_XW-1:0]   xin;
   logic                in_valid;
   logic [TIP_XW-1:0]   shreg;
   logic [TIP_PW-1:0]   pout;
   logic [2:0]          beat;
   logic                narrow_out;
   tip_state_t          state;
   logic                en;
   logic                dir_out;
   logic                link_en;
   logic                narrow_en;
   logic [TIP_C_CB_W-1:0] cb_sel;
   logic                ptick;
   logic                match;
   logic                time_ok;
   logic                stb_ok;
   logic                go;
   logic [TIP_PW-1:0]   pin_eff;
   logic [TIP_XW-1:0]   next_in;
   logic                wr_data;
   logic                rd_data;

   assign en        = ctrl[TIP_C_EN];
   assign dir_out   = ctrl[TIP_C_OUT];
   assign link_en   = ctrl[TIP_C_LINK];
   assign narrow_en = ctrl[TIP_C_NARROW];
   assign cb_sel    = ctrl[TIP_C_CB_LSB +: TIP_C_CB_W];
   assign wr_data   = wr_i && addr_i == TIP_OFS_DATA;
   assign rd_data   = rd_i && addr_i == TIP_OFS_DATA;

   // Two-flop synchronisers for everything arriving from the pin side.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_m <= '0;
         pin_s <= '0;
         stb_m <= 1'b0;
         stb_s <= 1'b0;
         eck_m <= 1'b0;
         eck_s <= 1'b0;
      end else begin
         pin_m <= pins_i;
         pin_s <= pin_m;
         stb_m <= strobe_in_i;
         stb_s <= stb_m;
         eck_m <= ext_clk_i;
         eck_s <= eck_m;
      end
   end

   // Reset-time pull-down enable for every pin.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulldown_o <= 1'b1; // RL17
      end else begin
         pulldown_o <= 1'b0;
      end
   end

   // Clock block zero is locked to the reference; the others are programmable.
   for (genvar g = 0; g < TIP_NCB; g++) begin : g_cb
      tip_clkblk #(
         .FIXED_REF (g == 0)
      ) u_cb (
         .clk_i     (clk_i),
         .rst_i     (rst_i),
         .ext_sel_i (cbcfg[g][TIP_CB_EXT]),
         .div_i     (cbcfg[g][TIP_CB_DIV_LSB +: TIP_DW]),
         .ext_clk_i (eck_s),
         .tick_o    (cb_tick[g])
      ); // RL12
   end

   // A selection beyond the last block simply stops the port.
   assign ptick = en && cb_sel < 3'(TIP_NCB) && cb_tick[cb_sel]; // RL15

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= '0;
      end else if (ptick) begin
         cnt <= cnt + 16'h0001; // RL18
      end
   end

   // Pins lent to the link or to the narrow port read as zero, but the port
   // still moves its full width so software never sees a shortened word.
   always_comb begin
      pin_eff = pin_s;
      if (link_en) begin
         pin_eff[TIP_LINK_LO +: TIP_LINK_N] = '0; // RL9
      end
      if (narrow_en) begin
         pin_eff[TIP_NARROW_PIN] = 1'b0; // RL10
      end
   end

   assign link_rx_o = link_en ? pin_s[TIP_LINK_LO +: TIP_LINK_N] : '0;
   assign match     = !ctrl[TIP_C_COND] || dir_out || pin_eff == cond; // RL2
   assign time_ok   = !ctrl[TIP_C_TIMED] || cnt == ttime; // RL19
   assign stb_ok    = dir_out || !ctrl[TIP_C_STBIN] || stb_s; // RL14
   assign go        = ptick && match && time_ok && stb_ok &&
                      (dir_out ? out_full : !in_valid); // RL6
   assign next_in   = {pin_eff, shreg[TIP_XW-1:TIP_PW]}; // RL11

   // Serializer: a transfer is TIP_NSH beats, lowest slice first.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= TIP_IDLE;
         shreg <= '0;
         pout  <= '0;
         beat  <= '0;
      end else begin
         case (state)
            TIP_IDLE: begin
               if (go && dir_out) begin
                  pout  <= xout[TIP_PW-1:0]; // RL5
                  shreg <= xout >> TIP_PW;
                  beat  <= 3'h1;
                  state <= TIP_RUN;
               end else if (go) begin
                  shreg <= next_in; // RL5
                  beat  <= 3'h1;
                  state <= TIP_RUN;
               end
            end
            TIP_RUN: begin
               if (!en) begin
                  state <= TIP_IDLE;
               end else if (ptick && beat == 3'(TIP_NSH)) begin
                  state <= TIP_IDLE;
               end else if (ptick && dir_out) begin
                  pout  <= shreg[TIP_PW-1:0];
                  shreg <= shreg >> TIP_PW;
                  beat  <= beat + 3'h1;
               end else if (ptick && stb_ok) begin
                  shreg <= next_in;
                  beat  <= beat + 3'h1;
               end
            end
            default: begin
               state <= TIP_IDLE;
            end
         endcase
      end
   end

   // Input word lands in the transfer register after its last beat.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         xin      <= '0;
         in_valid <= 1'b0;
      end else if (state == TIP_RUN && !dir_out && ptick && stb_ok &&
                   beat == 3'(TIP_NSH - 1)) begin
         xin      <= next_in; // RL5
         in_valid <= 1'b1;
      end else if (rd_data) begin
         in_valid <= 1'b0;
      end
   end

   // A write while the transfer register is still full is dropped, so the
   // core never waits; software checks the flags register first.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         xout     <= '0;
         out_full <= 1'b0;
      end else if (go && dir_out && state == TIP_IDLE) begin
         out_full <= 1'b0;
      end else if (wr_data && !out_full) begin
         xout     <= wdata_i; // RL3
         out_full <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tstamp <= '0;
      end else if (go && state == TIP_IDLE) begin
         tstamp <= cnt; // RL8
      end
   end

   // Outgoing strobe stands for exactly the beats that carry valid data.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strobe_out_o <= 1'b0;
      end else if (!en || !dir_out || !ctrl[TIP_C_STBOUT]) begin
         strobe_out_o <= 1'b0;
      end else if (ptick) begin
         strobe_out_o <= (state == TIP_IDLE) ? go : (beat != 3'(TIP_NSH)); // RL14
      end
   end

   // Pin drivers; the enable is active low while a pin is driven.
   for (genvar i = 0; i < TIP_PW; i++) begin : g_pin
      localparam bit LINKED = i >= TIP_LINK_LO && i < TIP_LINK_LO + TIP_LINK_N;
      // Kept in range for every pin, so unlinked pins never index out of bounds.
      localparam int LIDX = (i + TIP_LINK_N - TIP_LINK_LO) % TIP_LINK_N;
      always_comb begin
         if (LINKED && link_en) begin
            pins_o[i]      = link_tx_i[LIDX]; // RL9
            pins_oe_n_o[i] = link_oe_n_i[LIDX];
         end else if (i == TIP_NARROW_PIN && narrow_en) begin
            pins_o[i]      = narrow_out; // RL10
            pins_oe_n_o[i] = !ctrl[TIP_C_NOUT];
         end else if (en && dir_out && ctrl[TIP_C_OC]) begin
            pins_o[i]      = 1'b0; // RL4
            pins_oe_n_o[i] = pout[i];
         end else begin
            pins_o[i]      = pout[i]; // RL1
            pins_oe_n_o[i] = !(en && dir_out);
         end
      end
   end

   // Event sources for the status register and the scheduler.
   always_comb begin
      ev = '0;
      ev[TIP_S_IN]   = state == TIP_RUN && !dir_out && ptick && stb_ok &&
                       beat == 3'(TIP_NSH - 1);
      ev[TIP_S_OUT]  = state == TIP_RUN && dir_out && ptick && beat == 3'(TIP_NSH);
      ev[TIP_S_COND] = go && !dir_out && ctrl[TIP_C_COND] && state == TIP_IDLE;
      ev[TIP_S_TIME] = go && ctrl[TIP_C_TIMED] && state == TIP_IDLE;
   end

   // Scheduler events are unmasked pulses, separate from the interrupt.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         event_o <= 1'b0;
      end else begin
         event_o <= |ev; // RL16
      end
   end

   // Sticky status: a new event beats a write-one-to-clear in the same cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status <= '0;
      end else if (wr_i && addr_i == TIP_OFS_STATUS) begin
         status <= (status & ~wdata_i[TIP_S_W-1:0]) | ev;
      end else begin
         status <= status | ev;
      end
   end

   assign irq_o = |(status & mask);

   // Configuration registers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl       <= TIP_CTRL_RST; // RL15
         cond       <= '0;
         ttime      <= '0;
         mask       <= '0;
         narrow_out <= 1'b0;
      end else if (wr_i) begin
         case (addr_i)
            TIP_OFS_CTRL:   ctrl       <= wdata_i[TIP_C_W:0];
            TIP_OFS_COND:   cond       <= wdata_i[TIP_PW-1:0];
            TIP_OFS_TIME:   ttime      <= wdata_i[TIP_CW-1:0]; // RL7
            TIP_OFS_MASK:   mask       <= wdata_i[TIP_S_W-1:0];
            TIP_OFS_NARROW: narrow_out <= wdata_i[0];
            default: begin
            end
         endcase
      end
   end

   for (genvar c = 0; c < TIP_NCB; c++) begin : g_cbcfg
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cbcfg[c] <= TIP_CB_RST;
         end else if (wr_i && addr_i == TIP_OFS_CB0 + 8'(4 * c)) begin
            cbcfg[c] <= wdata_i[TIP_CB_W-1:0]; // RL13
         end
      end
   end

   // Read data stands in the cycle after the strobe; unmapped reads are zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         rdata_o <= '0;
         case (addr_i)
            TIP_OFS_CTRL:   rdata_o[TIP_C_W:0]    <= ctrl;
            TIP_OFS_DATA:   rdata_o               <= xin;
            TIP_OFS_COND:   rdata_o[TIP_PW-1:0]   <= cond;
            TIP_OFS_TIME:   rdata_o[TIP_CW-1:0]   <= ttime;
            TIP_OFS_COUNT:  rdata_o[TIP_CW-1:0]   <= cnt; // RL7
            TIP_OFS_TSTAMP: rdata_o[TIP_CW-1:0]   <= tstamp;
            TIP_OFS_STATUS: rdata_o[TIP_S_W-1:0]  <= status;
            TIP_OFS_MASK:   rdata_o[TIP_S_W-1:0]  <= mask;
            TIP_OFS_FLAGS:  rdata_o[1:0]          <= {in_valid, out_full};
            TIP_OFS_NARROW: rdata_o[1:0]          <= {pin_s[TIP_NARROW_PIN], narrow_out};
            default: begin
               for (int k = 0; k < TIP_NCB; k++) begin
                  if (addr_i == TIP_OFS_CB0 + 8'(4 * k)) begin
                     rdata_o[TIP_CB_W-1:0] <= cbcfg[k];
                  end
               end
            end
         endcase
      end
   end
endmodule

// ==== tip_port_props.sv ====
// Checker for the timed I/O port: bus, pin and transfer relations.
// Sees only the top ports and mirrors CTRL from the write strobe.
`timescale 1ns/10ps
module tip_port_props
   import tip_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic [7:0]            addr_i,
   input  wire logic [31:0]           wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   input  wire logic [31:0]           rdata_o,
   input  wire logic [TIP_PW-1:0]     pins_o,
   input  wire logic [TIP_PW-1:0]     pins_oe_n_o,
   input  wire logic                  pulldown_o,
   input  wire logic                  strobe_out_o,
   input  wire logic [TIP_LINK_N-1:0] link_tx_i,
   input  wire logic [TIP_LINK_N-1:0] link_oe_n_i,
   input  wire logic [TIP_LINK_N-1:0] link_rx_o
);
   logic [TIP_C_W:0] ctl;
   logic             plain;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A shadow of CTRL lets the pin checks know the mode without a read.
   always_ff @(posedge clk_i) begin
      if (rst_i) ctl <= TIP_CTRL_RST;
      else if (wr_i && addr_i == TIP_OFS_CTRL) ctl <= wdata_i[TIP_C_W:0];
   end
   assign plain = ctl[TIP_C_EN] & ~ctl[TIP_C_LINK] & ~ctl[TIP_C_NARROW];
   sequence cnt_rd;
      rd_i && addr_i == TIP_OFS_COUNT;
   endsequence
   sequence out_wr;
      wr_i && addr_i == TIP_OFS_DATA && ctl == 13'h0043 && !strobe_out_o;
   endsequence
   pulldown_rel_a: assert property (!rst_i |=> !pulldown_o)
      else $error("pull-down still on after reset");
   unmapped_rd_a: assert property (rd_i && addr_i == 8'h28 |=> rdata_o == 32'h0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!rd_i |=> $stable(rdata_o))
      else $error("read data moved without a read");
   oc_drive_a: assert property (ctl[TIP_C_OC] && plain |-> (pins_o & ~pins_oe_n_o) == 8'h00)
      else $error("open collector drove a one");
   input_float_a: assert property (plain && !ctl[TIP_C_OUT] |-> pins_oe_n_o == 8'hff)
      else $error("input port drives a pin");
   link_pins_a: assert property (ctl[TIP_C_EN] && ctl[TIP_C_LINK] |->
      pins_oe_n_o[7:4] == link_oe_n_i && pins_o[7:4] == link_tx_i)
      else $error("link does not own its pins");
   link_rx_a: assert property (!ctl[TIP_C_LINK] [*2] |-> link_rx_o == 4'h0)
      else $error("link receive active while off");
   strobe_len_a: assert property ($rose(strobe_out_o) |-> strobe_out_o [*4])
      else $error("outgoing strobe shorter than a word");
   count_step_a: assert property (ctl[TIP_C_EN] && ctl[11:9] == 3'h0 ##0 cnt_rd ##1 cnt_rd
      |=> rdata_o[15:0] == $past(rdata_o[15:0]) + 16'h0001)
      else $error("counter did not step by one");
   out_beats_a: assert property (out_wr |-> ##2 pins_o == $past(wdata_i[7:0], 2)
      ##1 pins_o == $past(wdata_i[15:8], 3) ##1 pins_o == $past(wdata_i[23:16], 4)
      ##1 pins_o == $past(wdata_i[31:24], 5))
      else $error("output beats wrong");
endmodule
bind tip_port tip_port_props chk (
   .clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pins_o, .pins_oe_n_o,
   .pulldown_o, .strobe_out_o, .link_tx_i, .link_oe_n_i, .link_rx_o
);

// ==== tip_pins_model.sv ====
// Board model on the pin side: pin levels, incoming strobe, external clock.
// Assumes a board pull-up on each pin; the reset pull-down overrides it.
`timescale 1ns/10ps
module tip_pins_model
   import tip_pkg::*;
(
   input  wire logic [TIP_PW-1:0] drive_i,
   input  wire logic [TIP_PW-1:0] oe_n_i,
   input  wire logic              pd_i,
   input  wire logic              drv_en_i,
   input  wire logic [TIP_PW-1:0] drv_val_i,
   input  wire logic              clk_run_i,
   input  wire logic              stb_i,
   output logic      [TIP_PW-1:0] wire_o,
   output logic                   ext_clk_o,
   output logic                   stb_o
);
   // A released pin takes the board drive when enabled, else its pull level, never the last driven value.
   always_comb begin
      for (int k = 0; k < TIP_PW; k++) begin
         if (!oe_n_i[k]) wire_o[k] = drive_i[k];
         else if (drv_en_i) wire_o[k] = drv_val_i[k];
         else wire_o[k] = ~pd_i;
      end
   end
   assign stb_o = stb_i;
   // The clock stands low between frames so tick counts stay exact.
   initial begin
      ext_clk_o = 1'b0;
      forever begin
         wait (clk_run_i);
         #160 ext_clk_o = 1'b1;
         #160 ext_clk_o = 1'b0;
      end
   end
endmodule

// ==== tip_port_tb.sv ====
// Self-checking bench for the timed I/O port, driven over its register port.
// Assumes the pin-side board model and the bound checker.
`timescale 1ns/10ps
module tip_port_tb;
   import tip_pkg::*;
   logic                  clk_i, rst_i, wr_i, rd_i, ext_clk_i, strobe_in_i;
   logic                  pulldown_o, strobe_out_o, irq_o, event_o, drv_en, clk_run, stb;
   logic [7:0]            addr_i, drv_val;
   logic [31:0]           wdata_i, rdata_o, v, a;
   logic [TIP_PW-1:0]     pins_i, pins_o, pins_oe_n_o;
   logic [TIP_LINK_N-1:0] link_tx_i, link_oe_n_i, link_rx_o;
   logic [15:0]           t;
   int                    num_errors, total_checks, nev;
   tip_port DUT (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pins_i,
      .pins_o, .pins_oe_n_o, .pulldown_o, .ext_clk_i, .strobe_in_i, .strobe_out_o,
      .link_tx_i, .link_oe_n_i, .link_rx_o, .irq_o, .event_o);
   tip_pins_model board (.drive_i(pins_o), .oe_n_i(pins_oe_n_o), .pd_i(pulldown_o),
      .drv_en_i(drv_en), .drv_val_i(drv_val), .clk_run_i(clk_run), .stb_i(stb),
      .wire_o(pins_i), .ext_clk_o(ext_clk_i), .stb_o(strobe_in_i));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= ad;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(negedge clk_i);
   endtask
   task automatic rd(input logic [7:0] ad, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= ad;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      d = rdata_o;
   endtask
   task automatic poll(input logic [7:0] ad, input int b);
      logic [31:0] d;
      int          n;
      n = 0;
      d = 32'h0;
      while (d[b] !== 1'b1 && n < 200) begin
         rd(ad, d);
         n++;
      end
      chk("poll", 32'h1, 32'(d[b]));
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (event_o === 1'b1) nev++;
   // The tests need about 270 cycles; the 10000-cycle limit means a hang.
   initial begin
      #400000;
      num_errors++;
      close_out();
   end
   initial begin
      {rst_i, drv_en, link_oe_n_i, drv_val} = {1'b1, 1'b1, 4'hf, 8'ha5};
      {addr_i, wdata_i, wr_i, rd_i, stb, link_tx_i, clk_run} = '0;
      {num_errors, total_checks, nev} = '0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("pulldown", 32'h1, 32'(pulldown_o));
      rd(TIP_OFS_CTRL, v);
      chk("ctrl", 32'h0, v);
      wr(8'h54, 32'h1ff);
      rd(8'h54, v);
      chk("cb5", 32'h1ff, v);
      wr(8'h28, 32'h1);
      rd(8'h28, v);
      chk("unmapped", 32'h0, v);
      rd(8'h58, v);
      chk("cb6", 32'h0, v);
      $display("test registers done");
      @(posedge clk_i);
      link_oe_n_i <= 4'h0;
      link_tx_i <= 4'ha;
      wr(TIP_OFS_CTRL, 32'h181);
      poll(TIP_OFS_FLAGS, 1);
      chk("irq masked", 32'h0, 32'(irq_o));
      rd(TIP_OFS_STATUS, v);
      chk("status in", 32'h1, 32'(v[TIP_S_IN]));
      wr(TIP_OFS_MASK, 32'h1);
      chk("irq on", 32'h1, 32'(irq_o));
      wr(TIP_OFS_STATUS, 32'h1);
      chk("irq cleared", 32'h0, 32'(irq_o));
      wr(TIP_OFS_MASK, 32'h0);
      chk("link rx", 32'ha, 32'(link_rx_o));
      rd(TIP_OFS_NARROW, v);
      chk("narrow", 32'h2, v);
      rd(TIP_OFS_DATA, v);
      chk("shared word", 32'h04040404, v);
      chk("events", 32'h1, 32'(nev > 0));
      $display("test input done");
      wr(TIP_OFS_CTRL, 32'h9);
      @(posedge clk_i);
      link_oe_n_i <= 4'hf;
      wr(TIP_OFS_COND, 32'h3c);
      rd(TIP_OFS_DATA, v);
      repeat (20) @(posedge clk_i);
      rd(TIP_OFS_FLAGS, v);
      chk("cond hold", 32'h0, 32'(v[1]));
      drv_val <= 8'h3c;
      poll(TIP_OFS_FLAGS, 1);
      rd(TIP_OFS_DATA, v);
      chk("cond word", 32'h3c3c3c3c, v);
      poll(TIP_OFS_STATUS, TIP_S_COND);
      wr(TIP_OFS_CTRL, 32'h21);
      rd(TIP_OFS_DATA, v);
      repeat (20) @(posedge clk_i);
      rd(TIP_OFS_FLAGS, v);
      chk("strobe hold", 32'h0, 32'(v[1]));
      stb <= 1'b1;
      poll(TIP_OFS_FLAGS, 1);
      stb <= 1'b0;
      $display("test conditions done");
      drv_en <= 1'b0;
      wr(TIP_OFS_CTRL, 32'h43);
      @(posedge clk_i);
      addr_i <= TIP_OFS_COUNT;
      rd_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rd_i <= 1'b0;
      wr(TIP_OFS_DATA, 32'h44332211);
      poll(TIP_OFS_STATUS, TIP_S_OUT);
      chk("last beat", 32'h44, 32'(pins_i));
      wr(TIP_OFS_CTRL, 32'h47);
      wr(TIP_OFS_STATUS, 32'hf);
      wr(TIP_OFS_DATA, 32'h5a00ff11);
      poll(TIP_OFS_STATUS, TIP_S_OUT);
      chk("open collector", 32'h5a, 32'(pins_i));
      $display("test output done");
      wr(TIP_OFS_CTRL, 32'h13);
      wr(TIP_OFS_STATUS, 32'hf);
      rd(TIP_OFS_COUNT, a);
      t = a[15:0] + 16'h0028;
      wr(TIP_OFS_TIME, 32'(t));
      wr(TIP_OFS_DATA, 32'h1);
      repeat (10) @(posedge clk_i);
      rd(TIP_OFS_FLAGS, v);
      chk("postponed", 32'h1, 32'(v[0]));
      poll(TIP_OFS_STATUS, TIP_S_TIME);
      rd(TIP_OFS_TSTAMP, v);
      chk("tstamp", 32'(t), v);
      $display("test timed done");
      wr(8'h44, 32'h3);
      wr(TIP_OFS_CTRL, 32'h201);
      rd(TIP_OFS_COUNT, a);
      clk_run <= 1'b1;
      #(8 * 320 - 100);
      clk_run <= 1'b0;
      repeat (10) @(posedge clk_i);
      rd(TIP_OFS_COUNT, v);
      chk("ext ticks", (a + 32'h4) & 32'hffff, v);
      wr(TIP_OFS_NARROW, 32'h0);
      wr(TIP_OFS_CTRL, 32'h1080);
      repeat (2) @(posedge clk_i);
      rd(TIP_OFS_NARROW, v);
      chk("narrow drive", 32'h0, v);
      $display("test clock block done");
      close_out();
   end
endmodule
